// [dv/btf_checker.sv]
// concurrent checks on the btf_top pins: thermal, blank, ref short, apb
module btf_checker #(
    parameter CH = 16,
    parameter BW = 7
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          latch_strobe,
    input wire logic          blank,
    input wire logic          thermal_shutdown,
    input wire logic          prewarn_in,
    input wire logic          ref_short_in,
    input wire logic [CH-1:0] sink_output,
    input wire logic          overtemp_error_flag,
    input wire logic          thermal_prewarning_flag
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pins cross two sync flops, so five cycles of a level is ample
    a_hot_off: assert property (
        thermal_shutdown [*5] |-> sink_output == '0)
        else $error("sinks on while hot");
    a_hot_flag: assert property (
        thermal_shutdown [*5] |-> overtemp_error_flag)
        else $error("thermal flag not set");
    // the flag may only drop a few cycles after a strobe rise
    a_flag_sticky: assert property (
        $fell(overtemp_error_flag) |->
        $past(latch_strobe, 3) || $past(latch_strobe, 4))
        else $error("thermal flag fell without strobe");
    a_warn_set: assert property (
        prewarn_in [*5] |-> thermal_prewarning_flag)
        else $error("warning flag not set");
    a_warn_clear: assert property (
        !prewarn_in [*5] |-> !thermal_prewarning_flag)
        else $error("warning flag latched");
    a_blank_off: assert property (
        blank [*5] |-> sink_output == '0)
        else $error("sinks on while blanked");
    a_ref_off: assert property (
        ref_short_in [*5] |-> sink_output == '0)
        else $error("sinks on with ref short");
    a_ready_wait: assert property (
        psel && $rose(penable) |=> pready ##1 !pready)
        else $error("ready not one wait state pulse");
    a_err_ready: assert property (
        pslverr |-> pready && psel && penable)
        else $error("error outside access");
endmodule // btf_checker

bind btf_top btf_checker #(.CH(CH), .BW(BW)) btf_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .latch_strobe(latch_strobe),
    .blank(blank), .thermal_shutdown(thermal_shutdown),
    .prewarn_in(prewarn_in), .ref_short_in(ref_short_in),
    .sink_output(sink_output), .overtemp_error_flag(overtemp_error_flag),
    .thermal_prewarning_flag(thermal_prewarning_flag)
);

// [dv/btf_host_model.sv]
// host controller model: serial frames, latch and blank pulses
module btf_host_model (
    input  wire  pclk,
    output logic sclk,
    output logic sin,
    output logic latch_strobe,
    output logic blank,
    input  wire  sout
);
    timeunit 1ns;
    timeprecision 100ps;
    // half period of the 160 ns link clock, counted in pclk cycles
    localparam HP = 20;
    initial begin
        sclk = 0;
        sin = 1;
        latch_strobe = 0;
        blank = 0;
    end
    // msb first; pins move by nba on a pclk rise, and the readback
    // bit is taken at the rise that launches each sclk rising edge
    task automatic frame(input logic [16:0] d, output logic [16:0] q);
        for (int i = 16; i >= 0; i--) begin
            sin <= d[i];
            repeat (HP) @(posedge pclk);
            q[i] = sout;
            sclk <= 1'b1;
            repeat (HP) @(posedge pclk);
            sclk <= 1'b0;
        end
        // idle data shows the inverse so a stale bit cannot pass
        sin <= ~d[0];
    endtask
    // twenty clocks high is far above the four the pins need
    task automatic pulse(input bit blk);
        if (blk) blank <= 1'b1;
        else latch_strobe <= 1'b1;
        repeat (HP) @(posedge pclk);
        if (blk) blank <= 1'b0;
        else latch_strobe <= 1'b0;
        repeat (HP) @(posedge pclk);
    endtask
endmodule // btf_host_model

// [dv/btf_top_tb.sv]
// self-checking bench for btf_top
module btf_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        sclk, sin, latch_strobe, blank, sout, irq, otf, pwf;
    logic        hot, warn, refs;
    logic [15:0] open_cmp, short_cmp, sink;
    logic [6:0]  bright;
    logic [16:0] q;
    int          mismatches, cmp_count, cyc, on_cnt;
    logic [16:0] row_f [5] = '{17'h0_A5C3, 17'h1_00FF, 17'h1_0100,
                               17'h1_01D5, 17'h1_002A};
    logic [11:0] row_a [5] = '{12'h008, 12'h004, 12'h004, 12'h004, 12'h004};
    logic [31:0] row_e [5] = '{32'h0000_A5C3, 32'h0000_017F, 32'h0000_0200,
                               32'h0000_0355, 32'h0000_002A};
    logic [6:0]  row_b [5] = '{7'h7F, 7'h7F, 7'h00, 7'h55, 7'h2A};

    btf_top #(.CH(16), .BW(7)) btf_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk(sclk), .sin(sin),
        .latch_strobe(latch_strobe), .blank(blank), .sout(sout),
        .thermal_shutdown(hot), .prewarn_in(warn), .ref_short_in(refs),
        .open_cmp(open_cmp), .short_cmp(short_cmp), .sink_output(sink),
        .global_brightness(bright), .overtemp_error_flag(otf),
        .thermal_prewarning_flag(pwf), .irq(irq));
    btf_host_model btf_host_model_inst (.pclk(pclk), .sclk(sclk), .sin(sin),
        .latch_strobe(latch_strobe), .blank(blank), .sout(sout));

    // clock
    initial begin
        pclk = 0;
        forever #2 pclk = ~pclk;
    end
    // hang guard, well above the roughly 10k cycles the run needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer; hold until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // only the bench's hang guard ends this wait
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    task automatic load(input logic [16:0] d);
        btf_host_model_inst.frame(d, q);
        btf_host_model_inst.pulse(0);
        tick(2);
    endtask
    task automatic blank_pulse();
        btf_host_model_inst.pulse(1);
        tick(2);
    endtask

    initial begin
        {psel, penable, pwrite, hot, warn, refs} = '0;
        {paddr, pwdata, open_cmp, short_cmp} = '0;
        presetn = 0;
        tick(16);
        presetn <= 1;
        // ordinary frames and their register view
        for (int i = 0; i < 5; i++) begin
            load(row_f[i]);
            rdc(row_a[i], row_e[i]);
            chk(32'(bright), 32'(row_b[i]));
            chk(32'(q[16:1]), 32'h0000_0000);
        end
        // mid-run reset, then reset values and an unmapped slot
        presetn <= 0;
        tick(16);
        presetn <= 1;
        for (int i = 0; i < 7; i++) begin
            rdc(12'(i * 4), i == 1 ? 32'h0000_007F : 32'h0000_0000);
            chk(32'(er), 32'(i == 6));
        end
        load(17'h0_FFFF);
        load(17'h1_00FF);
        apb(1, 12'h010, 32'h0000_000F);
        tick(4);
        chk(32'(sink), 32'h0000_FFFF);
        // open results masked by on/off data
        open_cmp <= 16'h3C3C;
        load(17'h0_0FF0);
        blank_pulse();
        rdc(12'h014, 32'h0000_0C30);
        load(17'h0_FFFF);
        // over-temperature
        hot <= 1;
        tick(10);
        chk(32'(sink), 32'h0000_0000);
        chk(32'({otf, irq}), 32'h0000_0003);
        rdc(12'h004, 32'h0000_317F);
        blank_pulse();
        rdc(12'h014, 32'h0000_FFFF);
        hot <= 0;
        tick(10);
        chk(32'({sink, otf}), 32'h0001_FFFF);
        apb(1, 12'h00C, 32'h0000_000F);
        tick(2);
        chk(32'(irq), 32'h0000_0000);
        load(17'h1_00FF);
        chk(32'({q[16:1], otf, irq}), 32'h0000_30C1);
        apb(1, 12'h010, 32'h0000_0000);
        tick(2);
        chk(32'(irq), 32'h0000_0000);
        // pre-warning; host answers with lower brightness
        warn <= 1;
        tick(10);
        chk(32'({sink, pwf}), 32'h0001_FFFF);
        load(17'h1_0120);
        chk(32'({q[16:1], bright}), 32'h007F_FFA0);
        rdc(12'h004, 32'h0000_4220);
        blank_pulse();
        rdc(12'h014, 32'h0000_FFFF);
        warn <= 0;
        short_cmp <= 16'h00FF;
        tick(10);
        chk(32'(pwf), 32'h0000_0000);
        blank_pulse();
        rdc(12'h014, 32'h0000_00FF);
        // reference short
        load(17'h1_01FF);
        refs <= 1;
        tick(10);
        chk(32'(sink), 32'h0000_0000);
        rdc(12'h004, 32'h0000_837F);
        blank_pulse();
        rdc(12'h014, 32'h0000_FFFF);
        refs <= 0;
        apb(1, 12'h000, 32'h0000_0001);
        tick(4);
        chk(32'(sink), 32'h0000_0000);
        apb(1, 12'h000, 32'h0000_0000);
        // duty over one 127-cycle frame equals the brightness value
        load(17'h1_0040);
        on_cnt = 0;
        repeat (127) begin
            @(posedge pclk);
            on_cnt += sink[0];
        end
        chk(32'(on_cnt), 32'h0000_0040);
        // select none: a blank capture empties the holder
        blank_pulse();
        rdc(12'h014, 32'h0000_0000);
        wrap_up();
    end
endmodule // btf_top_tb

// [src/btf_dimmer.v]
// duty-cycle generator scaling all sinks by brightness over full scale
`include "btf_regs.vh"
module btf_dimmer #(
    parameter W = 7
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] bright,
    output wire         dim_on
);

    reg  [W-1:0] cnt_ff;
    reg          on_ff;
    wire [W-1:0] nxt_cnt;

    // counter runs 0 .. full-1, so full scale is always on and 0 never on
    assign nxt_cnt = (cnt_ff == `BTF_BRIGHT_FULL - 7'h01) ? {W{1'b0}} :
                     cnt_ff + {{(W-1){1'b0}}, 1'b1};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= {W{1'b0}};
            on_ff  <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            on_ff  <= (bright > cnt_ff);
        end
    end

    assign dim_on = on_ff;

endmodule // btf_dimmer

// [src/btf_regs.vh]
// register offsets, field positions, reset values and counts for btf
`ifndef BTF_REGS_VH
`define BTF_REGS_VH

// apb byte offsets, one aligned word each
`define BTF_OFF_CTRL      12'h000
`define BTF_OFF_STATE     12'h004
`define BTF_OFF_ONOFF     12'h008
`define BTF_OFF_IRQ_STAT  12'h00C
`define BTF_OFF_IRQ_MASK  12'h010
`define BTF_OFF_HOLDER    12'h014

// ctrl fields
`define BTF_CTRL_FORCE_OFF 0

// state register fields
`define BTF_ST_BRIGHT_LSB  0
`define BTF_ST_SEL_LSB     8
`define BTF_ST_OTERR       12
`define BTF_ST_SHUTDOWN    13
`define BTF_ST_PREWARN     14
`define BTF_ST_REFSHORT    15

// interrupt status / mask bits
`define BTF_IRQ_OTERR      0
`define BTF_IRQ_PREWARN    1
`define BTF_IRQ_LATCH      2
`define BTF_IRQ_CAPTURE    3
`define BTF_IRQ_W          4

// serial frame: bit 16 chooses control latch (1) or on/off latch (0)
`define BTF_SHIFT_W        17
`define BTF_FRAME_SEL      16
`define BTF_CD_BRIGHT_LSB  0
`define BTF_CD_SEL_LSB     7

// status select codes
`define BTF_SEL_NONE       2'b00
`define BTF_SEL_OPEN       2'b01
`define BTF_SEL_SHORT      2'b10
`define BTF_SEL_REF        2'b11

// reset values
`define BTF_RST_BRIGHT     7'h7F
`define BTF_RST_SEL        2'b00
`define BTF_RST_ONOFF      16'h0000

// brightness scaling: duty is value over this full-scale count
`define BTF_BRIGHT_FULL    7'h7F

`endif

// [src/btf_sync.v]
// two-flop synchroniser for a bundle of asynchronous levels
module btf_sync #(
    parameter W = 1
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    // first stage feeds only the second stage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule // btf_sync

// [src/btf_top.v]
// brightness, on/off latch, thermal flags and status readout with apb view
//
// The implementer's own choices: the APB register port and the placing of the registers.
`include "btf_regs.vh"

// Notes on behaviour
// - one 7-bit brightness value scales all sixteen sinks together.
// - sink current is maximum times brightness over 127, 128 steps.
// - brightness arrives serially into the control latch and is kept.
// - each sink follows its bit in the host-written on/off latch.
// - over-temperature forces all sinks off and open-detect bits to one.
// - when over-temperature clears, sinks follow the latched on/off data.
// - thermal error flag stays one until the next latch strobe.
// - pre-warning sets its flag and forces short-detect bits to one.
// - pre-warning never forces the sinks off.
// - pre-warning flag clears as soon as the warning input drops.
// - fault results are readable back over the serial interface.
// - readout is all ones for thermal, warning, ref short per select.
// - open-detect results captured into 16-bit holder on blank rise.
module btf_top #(
    parameter CH = 16,
    parameter BW = 7
) (
    input  wire          pclk,
    input  wire          presetn,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output wire [31:0]   prdata,
    output wire          pready,
    output wire          pslverr,
    input  wire          sclk,
    input  wire          sin,
    input  wire          latch_strobe,
    input  wire          blank,
    output wire          sout,
    input  wire          thermal_shutdown,
    input  wire          prewarn_in,
    input  wire          ref_short_in,
    input  wire [CH-1:0] open_cmp,
    input  wire [CH-1:0] short_cmp,
    output wire [CH-1:0] sink_output,
    output wire [BW-1:0] global_brightness,
    output wire          overtemp_error_flag,
    output wire          thermal_prewarning_flag,
    output wire          irq
);

    localparam SW = 7 + 2 * CH;

    // synchronised pin levels
    wire [SW-1:0] pins_sync;
    wire          sclk_s;
    wire          sin_s;
    wire          lat_s;
    wire          blank_s;
    wire          shut_s;
    wire          warn_s;
    wire          refs_s;
    wire [CH-1:0] open_s;
    wire [CH-1:0] short_s;

    // edge history of the serial pins
    reg           sclk_d_ff;
    reg           lat_d_ff;
    reg           blank_d_ff;
    wire          sclk_rise;
    wire          lat_rise;
    wire          blank_rise;

    // serial path and latches
    reg  [`BTF_SHIFT_W-1:0] shift_ff;
    reg  [`BTF_SHIFT_W-1:0] nxt_shift;
    reg  [CH-1:0]           onoff_ff;
    reg  [BW-1:0]           bright_ff;
    reg  [1:0]              sel_ff;
    reg  [CH-1:0]           holder_ff;
    reg  [CH-1:0]           nxt_holder;
    reg                     sout_ff;

    // flags and outputs
    reg           oterr_ff;
    reg           warn_ff;
    reg  [CH-1:0] sink_ff;
    wire [CH-1:0] open_bits;
    wire [CH-1:0] short_bits;
    wire          dim_on;

    // apb side
    reg                   force_off_ff;
    reg  [`BTF_IRQ_W-1:0] irq_stat_ff;
    reg  [`BTF_IRQ_W-1:0] irq_mask_ff;
    reg  [`BTF_IRQ_W-1:0] nxt_irq_stat;
    reg  [`BTF_IRQ_W-1:0] irq_ev;
    reg                   irq_ff;
    reg                   pready_ff;
    reg                   pslverr_ff;
    reg  [31:0]           prdata_ff;
    reg  [31:0]           nxt_prdata;
    reg                   nxt_err;
    reg                   warn_d_ff;
    wire                  apb_take;
    wire                  apb_wr;

    // every pin from outside except the apb bus passes two flops before use
    btf_sync #(
        .W (SW)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({short_cmp, open_cmp, ref_short_in, prewarn_in,
                    thermal_shutdown, blank, latch_strobe, sin, sclk}),
        .sync_out (pins_sync)
    );

    assign sclk_s  = pins_sync[0];
    assign sin_s   = pins_sync[1];
    assign lat_s   = pins_sync[2];
    assign blank_s = pins_sync[3];
    assign shut_s  = pins_sync[4];
    assign warn_s  = pins_sync[5];
    assign refs_s  = pins_sync[6];
    assign open_s  = pins_sync[7 +: CH];
    assign short_s = pins_sync[7 + CH +: CH];

    // edges are found on synchronised copies only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d_ff  <= 1'b0;
            lat_d_ff   <= 1'b0;
            blank_d_ff <= 1'b0;
        end else begin
            sclk_d_ff  <= sclk_s;
            lat_d_ff   <= lat_s;
            blank_d_ff <= blank_s;
        end
    end

    assign sclk_rise  = sclk_s & ~sclk_d_ff;
    assign lat_rise   = lat_s & ~lat_d_ff;
    assign blank_rise = blank_s & ~blank_d_ff;

    // shared duty generator: current ratio is brightness over full scale
    btf_dimmer #(
        .W (BW)
    ) u_dim (
        .pclk    (pclk),
        .presetn (presetn),
        .bright  (bright_ff),
        .dim_on  (dim_on)
    );

    // detect data valid only for sinks that are programmed on;
    // thermal conditions overwrite the whole group
    assign open_bits  = shut_s ? {CH{1'b1}} : (open_s & onoff_ff);
    assign short_bits = warn_s ? {CH{1'b1}} : (short_s & onoff_ff);

    // shift on sclk rise; a latch strobe reloads the readout afterwards
    always @* begin
        nxt_shift = shift_ff;
        if (lat_rise) begin
            nxt_shift = {holder_ff, 1'b0};
        end else if (sclk_rise) begin
            nxt_shift = {shift_ff[`BTF_SHIFT_W-2:0], sin_s};
        end
    end

    // holder content per select, thermal and ref short give all ones
    always @* begin
        nxt_holder = holder_ff;
        if (blank_rise) begin
            case (sel_ff)
                `BTF_SEL_OPEN: begin
                    nxt_holder = oterr_ff ? {CH{1'b1}} : open_bits;
                end
                `BTF_SEL_SHORT: begin
                    nxt_holder = warn_ff ? {CH{1'b1}} : short_bits;
                end
                `BTF_SEL_REF: begin
                    nxt_holder = refs_s ? {CH{1'b1}} : {CH{1'b0}};
                end
                default: begin
                    nxt_holder = {CH{1'b0}};
                end
            endcase
        end
    end

    // latches load from the frame on the strobe edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_ff  <= {`BTF_SHIFT_W{1'b0}};
            onoff_ff  <= `BTF_RST_ONOFF;
            bright_ff <= `BTF_RST_BRIGHT;
            sel_ff    <= `BTF_RST_SEL;
            holder_ff <= {CH{1'b0}};
            sout_ff   <= 1'b0;
        end else begin
            shift_ff  <= nxt_shift;
            holder_ff <= nxt_holder;
            sout_ff   <= nxt_shift[`BTF_SHIFT_W-1];
            if (lat_rise) begin
                if (shift_ff[`BTF_FRAME_SEL]) begin
                    bright_ff <= shift_ff[`BTF_CD_BRIGHT_LSB +: BW];
                    sel_ff    <= shift_ff[`BTF_CD_SEL_LSB +: 2];
                end else begin
                    onoff_ff  <= shift_ff[CH-1:0];
                end
            end
        end
    end

    // thermal error: set while hot, held until a strobe; set wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oterr_ff <= 1'b0;
        end else if (shut_s) begin
            oterr_ff <= 1'b1;
        end else if (lat_rise) begin
            oterr_ff <= 1'b0;
        end
    end

    // pre-warning follows its input without latching
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn_ff   <= 1'b0;
            warn_d_ff <= 1'b0;
        end else begin
            warn_ff   <= warn_s;
            warn_d_ff <= warn_ff;
        end
    end

    // sinks: shutdown, ref short, blank or software force turn all off;
    // pre-warning deliberately absent so a warm part keeps running
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sink_ff <= {CH{1'b0}};
        end else if (shut_s | refs_s | blank_s | force_off_ff) begin
            sink_ff <= {CH{1'b0}};
        end else begin
            sink_ff <= onoff_ff & {CH{dim_on}};
        end
    end

    // apb: one wait state so read data come from a flop
    assign apb_take = psel & penable & pready_ff;
    assign apb_wr   = apb_take & pwrite & ~pslverr_ff;

    // read mux and decode of unmapped offsets
    always @* begin
        nxt_prdata = 32'h0000_0000;
        nxt_err    = 1'b0;
        case (paddr)
            `BTF_OFF_CTRL: begin
                nxt_prdata[`BTF_CTRL_FORCE_OFF] = force_off_ff;
            end
            `BTF_OFF_STATE: begin
                nxt_prdata[`BTF_ST_BRIGHT_LSB +: BW] = bright_ff;
                nxt_prdata[`BTF_ST_SEL_LSB +: 2]     = sel_ff;
                nxt_prdata[`BTF_ST_OTERR]            = oterr_ff;
                nxt_prdata[`BTF_ST_SHUTDOWN]         = shut_s;
                nxt_prdata[`BTF_ST_PREWARN]          = warn_ff;
                nxt_prdata[`BTF_ST_REFSHORT]         = refs_s;
            end
            `BTF_OFF_ONOFF: begin
                nxt_prdata[CH-1:0] = onoff_ff;
            end
            `BTF_OFF_IRQ_STAT: begin
                nxt_prdata[`BTF_IRQ_W-1:0] = irq_stat_ff;
            end
            `BTF_OFF_IRQ_MASK: begin
                nxt_prdata[`BTF_IRQ_W-1:0] = irq_mask_ff;
            end
            `BTF_OFF_HOLDER: begin
                nxt_prdata[CH-1:0] = holder_ff;
            end
            default: begin
                nxt_err = 1'b1;
            end
        endcase
    end

    // access phase answer, held one cycle then released
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= psel & penable & ~pready_ff;
            pslverr_ff <= psel & penable & ~pready_ff & nxt_err;
            if (psel & penable & ~pready_ff & ~pwrite) begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    // software control and mask writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_off_ff <= 1'b0;
            irq_mask_ff  <= {`BTF_IRQ_W{1'b0}};
        end else if (apb_wr) begin
            if (paddr == `BTF_OFF_CTRL) begin
                force_off_ff <= pwdata[`BTF_CTRL_FORCE_OFF];
            end
            if (paddr == `BTF_OFF_IRQ_MASK) begin
                irq_mask_ff <= pwdata[`BTF_IRQ_W-1:0];
            end
        end
    end

    // events: thermal error rise, warning rise, strobe, holder capture
    always @* begin
        irq_ev = {`BTF_IRQ_W{1'b0}};
        irq_ev[`BTF_IRQ_OTERR]   = shut_s & ~oterr_ff;
        irq_ev[`BTF_IRQ_PREWARN] = warn_ff & ~warn_d_ff;
        irq_ev[`BTF_IRQ_LATCH]   = lat_rise;
        irq_ev[`BTF_IRQ_CAPTURE] = blank_rise;
        nxt_irq_stat = irq_stat_ff;
        if (apb_wr && (paddr == `BTF_OFF_IRQ_STAT)) begin
            nxt_irq_stat = irq_stat_ff & ~pwdata[`BTF_IRQ_W-1:0];
        end
        // an event in the clearing cycle must not be lost
        nxt_irq_stat = nxt_irq_stat | irq_ev;
    end

    // sticky status and registered level interrupt
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= {`BTF_IRQ_W{1'b0}};
            irq_ff      <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            irq_ff      <= |(nxt_irq_stat & irq_mask_ff);
        end
    end

    assign prdata                  = prdata_ff;
    assign pready                  = pready_ff;
    assign pslverr                 = pslverr_ff;
    assign sout                    = sout_ff;
    assign sink_output             = sink_ff;
    assign global_brightness       = bright_ff;
    assign overtemp_error_flag     = oterr_ff;
    assign thermal_prewarning_flag = warn_ff;
    assign irq                     = irq_ff;

endmodule // btf_top
